// file: common/abx_pkg.sv
// constants, types and opcode field helpers for the execution block
package abx_pkg;

  localparam int PC_W   = 12;
  localparam int DATA_W = 8;

  localparam logic [PC_W-1:0]   PC_RESET       = 12'h000;
  localparam logic [PC_W-1:0]   PC_STEP        = 12'h001;
  localparam logic [PC_W-1:0]   SHORT_FWD_BIAS = 12'h001;
  localparam logic [PC_W-1:0]   BTB_BIAS       = 12'h002;
  localparam logic [DATA_W-1:0] BYTE_ZERO      = 8'h00;
  localparam logic [DATA_W-1:0] REG_PTR_X      = 8'h80;
  localparam logic [DATA_W-1:0] REG_PTR_Y      = 8'h81;
  localparam logic [DATA_W-1:0] REG_SHORT_BASE = 8'h80;
  localparam int                STACK_DEPTH    = 6;

  typedef enum logic [5:0] {
    ST_FETCH  = 6'h01,
    ST_OPND1  = 6'h02,
    ST_OPND2  = 6'h04,
    ST_READ   = 6'h08,
    ST_COMMIT = 6'h10,
    ST_HALT   = 6'h20
  } abx_state_type;

  typedef enum logic [3:0] {
    CL_BRANCH = 4'h0, CL_JUMP = 4'h1, CL_CALL = 4'h2, CL_BITSC = 4'h3, CL_BITTB = 4'h4,
    CL_ALU    = 4'h5, CL_SHORT = 4'h6, CL_ACC = 4'h7, CL_CTRL = 4'h8
  } abx_class_type;

  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_AND = 4'h1, ALU_CP  = 4'h2, ALU_SUB = 4'h3, ALU_CLR = 4'h4,
    ALU_INC = 4'h5, ALU_DEC = 4'h6, ALU_NONE = 4'h7, ALU_COM = 4'h8, ALU_RLC = 4'h9,
    ALU_SLA = 4'ha
  } abx_alu_type;

  typedef enum logic [1:0] {
    MODE_DIRECT = 2'h0, MODE_IMM = 2'h1, MODE_IND_X = 2'h2, MODE_IND_Y = 2'h3
  } abx_mode_type;

  typedef enum logic [2:0] {
    CTL_NOP = 3'h0, CTL_RET = 3'h1, CTL_RETURN_FROM_INTERRUPT = 3'h2, CTL_STOP = 3'h3, CTL_WAIT = 3'h4
  } abx_ctl_type;

  // opcode byte layout
  function automatic abx_class_type abx_class(input logic [7:0] op);
    if (!op[7]) return CL_BRANCH;
    case (op[6:4])
      3'h0: return CL_JUMP;
      3'h1: return CL_CALL;
      3'h2: return CL_BITSC;
      3'h3: return CL_BITTB;
      3'h4, 3'h5: return CL_ALU;
      3'h6: return CL_SHORT;
      default: return op[3] ? CL_CTRL : CL_ACC;
    endcase
  endfunction

  function automatic abx_mode_type abx_mode(input logic [7:0] op);
    return abx_mode_type'(op[1:0]);
  endfunction

  function automatic abx_alu_type abx_alu_sel(input logic [7:0] op);
    abx_class_type c;
    c = abx_class(op);
    if (c == CL_ALU) begin
      if (op[4:2] > 3'h3 && abx_mode(op) == MODE_IMM) return ALU_NONE;
      return abx_alu_type'({1'b0, op[4:2]});
    end
    if (c == CL_SHORT) return op[2] ? ALU_INC : ALU_DEC;
    if (c == CL_ACC && op[1:0] != 2'h3) return abx_alu_type'({2'b10, op[1:0]});
    return ALU_NONE;
  endfunction

  function automatic logic [2:0]  abx_bit_sel(input logic [7:0] op); return op[2:0]; endfunction
  function automatic logic        abx_bit_pol(input logic [7:0] op); return op[3];   endfunction
  function automatic logic [1:0]  abx_cond(input logic [7:0] op);    return op[6:5]; endfunction
  function automatic logic        abx_back(input logic [7:0] op);    return op[4];   endfunction
  function automatic logic [3:0]  abx_span(input logic [7:0] op);    return op[3:0]; endfunction
  function automatic logic [3:0]  abx_page(input logic [7:0] op);    return op[3:0]; endfunction
  function automatic abx_ctl_type abx_ctl(input logic [7:0] op);
    return abx_ctl_type'(op[2:0]);
  endfunction

endpackage

// file: core/abx_alu.sv
// accumulator and data-space arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module abx_alu
  import abx_pkg::*;
(
  input  wire abx_alu_type     op,
  input  wire logic [7:0]      a,
  input  wire logic [7:0]      b,
  input  wire logic            cin,
  output logic [7:0]           res,
  output logic                 zout,
  output logic                 cout,
  output logic                 upd_z,
  output logic                 upd_c,
  output logic                 wr_acc,
  output logic                 wr_mem
);
  logic [8:0] wide;

  always_comb begin
    wide   = {1'b0, a} - {1'b0, b};
    res    = a;
    cout   = cin;
    upd_z  = 1'b1;
    upd_c  = 1'b1;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    case (op)
      ALU_ADD: begin
        wide   = {1'b0, a} + {1'b0, b};
        res    = wide[7:0];
        cout   = wide[8];
        wr_acc = 1'b1;
      end
      ALU_AND: begin
        res    = a & b;
        cout   = 1'b0;
        wr_acc = 1'b1;
      end
      ALU_CP: begin
        res  = wide[7:0];
        cout = wide[8];
      end
      ALU_SUB: begin
        res    = wide[7:0];
        cout   = wide[8];
        wr_acc = 1'b1;
      end
      ALU_CLR: begin
        res    = BYTE_ZERO;
        upd_z  = 1'b0;
        upd_c  = 1'b0;
        wr_mem = 1'b1;
      end
      ALU_INC: begin
        res    = b + 8'h01;
        upd_c  = 1'b0;
        wr_mem = 1'b1;
      end
      ALU_DEC: begin
        res    = b - 8'h01;
        upd_c  = 1'b0;
        wr_mem = 1'b1;
      end
      ALU_COM: begin
        res    = ~a;
        cout   = a[7];
        wr_acc = 1'b1;
      end
      ALU_RLC: begin
        res    = {a[6:0], cin};
        cout   = a[7];
        wr_acc = 1'b1;
      end
      ALU_SLA: begin
        res    = {a[6:0], 1'b0};
        cout   = a[7];
        wr_acc = 1'b1;
      end
      default: begin
        upd_z = 1'b0;
        upd_c = 1'b0;
      end
    endcase
    zout = (res == BYTE_ZERO);
  end
endmodule
`default_nettype wire

// file: core/abx_exec.sv
// multi-cycle executor for arithmetic, branch, bit, jump and control instructions
`timescale 1ns/1ps
`default_nettype none
module abx_exec
  import abx_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset,
  output logic [PC_W-1:0]        prog_addr,
  input  wire logic [7:0]        prog_rdata,
  output logic [7:0]             data_addr,
  input  wire logic [7:0]        data_rdata,
  output logic [7:0]             data_wdata,
  output logic                   data_we,
  input  wire logic              watchdog_enabled,
  input  wire logic              wake,
  output logic [7:0]             acc_value,
  output logic                   carry_flag,
  output logic                   zero_flag,
  output logic                   wait_mode,
  output logic                   stop_mode,
  output logic                   irq_return,
  output logic                   instr_done
);
  abx_state_type   state_r, state_nxt;
  logic [7:0]      opcode_r, opcode_nxt;
  logic [PC_W-1:0] instr_addr_r, instr_addr_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [7:0]      data_addr_r, data_addr_nxt;
  logic [7:0]      data_wdata_r, data_wdata_nxt;
  logic            data_we_r, data_we_nxt;
  logic [7:0]      imm_r, imm_nxt;
  logic [7:0]      acc_r, acc_nxt;
  logic            carry_r, carry_nxt;
  logic            zero_r, zero_nxt;
  logic            wait_mode_r, wait_mode_nxt;
  logic            stop_mode_r, stop_mode_nxt;
  logic            irq_return_r, irq_return_nxt;
  logic            instr_done_r, instr_done_nxt;
  logic [PC_W-1:0] stack_r   [STACK_DEPTH];
  logic [PC_W-1:0] stack_nxt [STACK_DEPTH];

  abx_class_type   cls_f, cls_x;
  abx_mode_type    mode_x;
  abx_alu_type     alu_op;
  logic [7:0]      alu_b, alu_res, bit_mask;
  logic            alu_z, alu_c, alu_uz, alu_uc, alu_wa, alu_wm;
  logic            tested_bit, taken;

  // short branch: forward adds span+1, backward subtracts span
  function automatic logic [PC_W-1:0] short_target(input logic [PC_W-1:0] base,
                                                   input logic [7:0] op);
    logic [PC_W-1:0] span;
    span = {8'h00, abx_span(op)};
    if (abx_back(op)) return base - span;
    return base + span + SHORT_FWD_BIAS;
  endfunction

  // bit branch: signed byte plus two
  function automatic logic [PC_W-1:0] btb_target(input logic [PC_W-1:0] base,
                                                 input logic [7:0] disp);
    return base + BTB_BIAS + {{4{disp[7]}}, disp};
  endfunction

  assign cls_f  = abx_class(prog_rdata);
  assign cls_x  = abx_class(opcode_r);
  assign mode_x = abx_mode(opcode_r);
  assign alu_op = abx_alu_sel(opcode_r);
  assign alu_b  = (cls_x == CL_ALU && mode_x == MODE_IMM) ? imm_r : data_rdata;
  assign bit_mask   = 8'h01 << abx_bit_sel(opcode_r);
  assign tested_bit = |(data_rdata & bit_mask);

  abx_alu u_alu (
    .op     (alu_op),
    .a      (acc_r),
    .b      (alu_b),
    .cin    (carry_r),
    .res    (alu_res),
    .zout   (alu_z),
    .cout   (alu_c),
    .upd_z  (alu_uz),
    .upd_c  (alu_uc),
    .wr_acc (alu_wa),
    .wr_mem (alu_wm)
  );

  always_comb begin
    state_nxt      = state_r;
    opcode_nxt     = opcode_r;
    instr_addr_nxt = instr_addr_r;
    pc_nxt         = pc_r;
    data_addr_nxt  = data_addr_r;
    data_wdata_nxt = data_wdata_r;
    data_we_nxt    = 1'b0;
    imm_nxt        = imm_r;
    acc_nxt        = acc_r;
    carry_nxt      = carry_r;
    zero_nxt       = zero_r;
    wait_mode_nxt  = wait_mode_r;
    stop_mode_nxt  = stop_mode_r;
    irq_return_nxt = 1'b0;
    instr_done_nxt = 1'b0;
    stack_nxt      = stack_r;
    taken          = 1'b0;
    case (state_r)
      ST_FETCH: begin
        opcode_nxt     = prog_rdata;
        instr_addr_nxt = pc_r;
        pc_nxt         = pc_r + PC_STEP;
        if (cls_f == CL_BRANCH || cls_f == CL_CTRL) begin
          state_nxt = ST_COMMIT;
        end else begin
          state_nxt = ST_OPND1;
        end
        if (cls_f == CL_ALU && abx_mode(prog_rdata) == MODE_IND_X) begin
          data_addr_nxt = REG_PTR_X;
        end else if (cls_f == CL_ALU && abx_mode(prog_rdata) == MODE_IND_Y) begin
          data_addr_nxt = REG_PTR_Y;
        end else if (cls_f == CL_SHORT) begin
          data_addr_nxt = REG_SHORT_BASE | {6'h00, prog_rdata[1:0]};
        end
      end
      ST_OPND1: begin
        state_nxt = (cls_x == CL_BITTB) ? ST_OPND2 : ST_READ;
        if (cls_x == CL_JUMP || cls_x == CL_CALL ||
            (cls_x == CL_ALU && mode_x == MODE_IMM)) begin
          imm_nxt = prog_rdata;
          pc_nxt  = pc_r + PC_STEP;
        end else if (cls_x == CL_BITSC || cls_x == CL_BITTB ||
                     (cls_x == CL_ALU && mode_x == MODE_DIRECT)) begin
          data_addr_nxt = prog_rdata;
          pc_nxt        = pc_r + PC_STEP;
        end else if (cls_x == CL_ALU) begin
          data_addr_nxt = data_rdata;
        end
      end
      ST_OPND2: begin
        imm_nxt   = prog_rdata;
        pc_nxt    = pc_r + PC_STEP;
        state_nxt = ST_READ;
      end
      ST_READ: begin
        state_nxt = ST_COMMIT;
        if (cls_x == CL_JUMP || cls_x == CL_CALL) begin
          pc_nxt = {abx_page(opcode_r), imm_r};
          if (cls_x == CL_CALL) begin
            for (int i = STACK_DEPTH - 1; i > 0; i--) stack_nxt[i] = stack_r[i-1];
            stack_nxt[0] = pc_r;
          end
        end else if (cls_x == CL_BITSC) begin
          data_we_nxt    = 1'b1;
          data_wdata_nxt = abx_bit_pol(opcode_r) ? (data_rdata | bit_mask)
                                                 : (data_rdata & ~bit_mask);
        end else if (cls_x == CL_BITTB) begin
          carry_nxt = tested_bit;
          if (tested_bit == abx_bit_pol(opcode_r)) begin
            pc_nxt = btb_target(instr_addr_r, imm_r);
          end
        end else begin
          if (alu_wa) acc_nxt = alu_res;
          if (alu_uz) zero_nxt = alu_z;
          if (alu_uc) carry_nxt = alu_c;
          if (alu_wm) begin
            data_we_nxt    = 1'b1;
            data_wdata_nxt = alu_res;
          end
        end
      end
      ST_COMMIT: begin
        state_nxt      = ST_FETCH;
        instr_done_nxt = 1'b1;
        if (cls_x == CL_BRANCH) begin
          case (abx_cond(opcode_r))
            2'h0:    taken = !zero_r;
            2'h1:    taken = !carry_r;
            2'h2:    taken = zero_r;
            default: taken = carry_r;
          endcase
          if (taken) pc_nxt = short_target(instr_addr_r, opcode_r);
        end else if (cls_x == CL_CTRL) begin
          case (abx_ctl(opcode_r))
            CTL_RET, CTL_RETURN_FROM_INTERRUPT: begin
              pc_nxt = stack_r[0];
              for (int i = 0; i < STACK_DEPTH - 1; i++) stack_nxt[i] = stack_r[i+1];
              stack_nxt[STACK_DEPTH-1] = PC_RESET;
              irq_return_nxt = (abx_ctl(opcode_r) == CTL_RETURN_FROM_INTERRUPT);
            end
            CTL_STOP: begin
              state_nxt     = ST_HALT;
              wait_mode_nxt = watchdog_enabled;
              stop_mode_nxt = !watchdog_enabled;
            end
            CTL_WAIT: begin
              state_nxt     = ST_HALT;
              wait_mode_nxt = 1'b1;
            end
            default: ;
          endcase
        end
      end
      ST_HALT: begin
        if (wake) begin
          state_nxt     = ST_FETCH;
          wait_mode_nxt = 1'b0;
          stop_mode_nxt = 1'b0;
        end
      end
      default: state_nxt = ST_FETCH;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r      <= ST_FETCH;
      opcode_r     <= BYTE_ZERO;
      instr_addr_r <= PC_RESET;
      pc_r         <= PC_RESET;
      data_addr_r  <= BYTE_ZERO;
      data_wdata_r <= BYTE_ZERO;
      data_we_r    <= 1'b0;
      imm_r        <= BYTE_ZERO;
      acc_r        <= BYTE_ZERO;
      carry_r      <= 1'b0;
      zero_r       <= 1'b0;
      wait_mode_r  <= 1'b0;
      stop_mode_r  <= 1'b0;
      irq_return_r <= 1'b0;
      instr_done_r <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++) stack_r[i] <= PC_RESET;
    end else begin
      state_r      <= state_nxt;
      opcode_r     <= opcode_nxt;
      instr_addr_r <= instr_addr_nxt;
      pc_r         <= pc_nxt;
      data_addr_r  <= data_addr_nxt;
      data_wdata_r <= data_wdata_nxt;
      data_we_r    <= data_we_nxt;
      imm_r        <= imm_nxt;
      acc_r        <= acc_nxt;
      carry_r      <= carry_nxt;
      zero_r       <= zero_nxt;
      wait_mode_r  <= wait_mode_nxt;
      stop_mode_r  <= stop_mode_nxt;
      irq_return_r <= irq_return_nxt;
      instr_done_r <= instr_done_nxt;
      stack_r      <= stack_nxt;
    end
  end

  assign prog_addr  = pc_r;
  assign data_addr  = data_addr_r;
  assign data_wdata = data_wdata_r;
  assign data_we    = data_we_r;
  assign acc_value  = acc_r;
  assign carry_flag = carry_r;
  assign zero_flag  = zero_r;
  assign wait_mode  = wait_mode_r;
  assign stop_mode  = stop_mode_r;
  assign irq_return = irq_return_r;
  assign instr_done = instr_done_r;
endmodule
`default_nettype wire

// file: bench/abx_exec_sva.sv
// concurrent checks on the execution block ports
`timescale 1ns/1ps
`default_nettype none
module abx_exec_sva
  import abx_pkg::*;
(
  input wire logic            clock,
  input wire logic            reset,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic [7:0]      prog_rdata,
  input wire logic [7:0]      data_addr,
  input wire logic [7:0]      data_rdata,
  input wire logic [7:0]      data_wdata,
  input wire logic            data_we,
  input wire logic            watchdog_enabled,
  input wire logic            wake,
  input wire logic [7:0]      acc_value,
  input wire logic            carry_flag,
  input wire logic            zero_flag,
  input wire logic            wait_mode,
  input wire logic            stop_mode,
  input wire logic            irq_return,
  input wire logic            instr_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic tk;
  logic sb;
  assign tk = (prog_rdata[5] ? carry_flag : zero_flag) == prog_rdata[6];
  assign sb = instr_done && !prog_rdata[7];
  property p_we_pulse; data_we |=> !data_we; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("strobe too long");
  property p_len_short; sb |=> !instr_done ##1 instr_done; endproperty
  a_len_short: assert property (p_len_short) else $error("short length");
  property p_len_alu;
    instr_done && prog_rdata[7:5] == 3'h6 |=> !instr_done [*3] ##1 instr_done;
  endproperty
  a_len_alu: assert property (p_len_alu) else $error("alu length");
  property p_len_bit;
    instr_done && prog_rdata[7:4] == 4'hb |=> !instr_done [*4] ##1 instr_done;
  endproperty
  a_len_bit: assert property (p_len_bit) else $error("bit test length");
  property p_not_taken; sb && !tk |-> ##2 prog_addr == $past(prog_addr, 2) + 12'h001; endproperty
  a_not_taken: assert property (p_not_taken) else $error("branch not expected");
  property p_fwd;
    sb && tk && !prog_rdata[4] |-> ##2
      prog_addr == $past(prog_addr, 2) + {8'h00, $past(prog_rdata[3:0], 2)} + 12'h001;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward target");
  property p_back;
    sb && tk && prog_rdata[4] |-> ##2
      prog_addr == $past(prog_addr, 2) - {8'h00, $past(prog_rdata[3:0], 2)};
  endproperty
  a_back: assert property (p_back) else $error("backward target");
  property p_jump;
    instr_done && prog_rdata[7:4] == 4'h8 |-> ##4
      prog_addr == {$past(prog_rdata[3:0], 4), $past(prog_rdata, 3)};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target");
  property p_bit_carry;
    instr_done && prog_rdata[7:4] == 4'ha |=> $stable(carry_flag) [*4];
  endproperty
  a_bit_carry: assert property (p_bit_carry) else $error("carry moved");
  property p_short_carry;
    instr_done && prog_rdata[7:4] == 4'he |=> $stable(carry_flag) [*4];
  endproperty
  a_short_carry: assert property (p_short_carry) else $error("carry moved");
  property p_no_stop; watchdog_enabled |-> !$rose(stop_mode); endproperty
  a_no_stop: assert property (p_no_stop) else $error("stop under watchdog");
endmodule
`default_nettype wire

// file: bench/abx_exec_tb.sv
// self-checking bench for the execution block
`timescale 1ns/1ps
`default_nettype none
module abx_exec_tb
  import abx_pkg::*;
;
  logic            clock, reset, watchdog_enabled, wake, data_we, carry_flag, zero_flag;
  logic            wait_mode, stop_mode, irq_return, instr_done, cf, zf, irq_seen;
  logic [PC_W-1:0] prog_addr, pc;
  logic [7:0]      prog_rdata, data_addr, data_rdata, data_wdata, acc_value, acc;
  logic [7:0]      rom [0:4095];
  logic [7:0]      ram [0:255];
  logic [11:0]     stk [$];
  logic [31:0]     seed;
  int              fails, comparisons, cycles;

  abx_exec u_abx_exec (.clock(clock), .reset(reset), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata), .data_addr(data_addr), .data_rdata(data_rdata),
    .data_wdata(data_wdata), .data_we(data_we), .watchdog_enabled(watchdog_enabled),
    .wake(wake), .acc_value(acc_value), .carry_flag(carry_flag), .zero_flag(zero_flag),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .irq_return(irq_return),
    .instr_done(instr_done));

  assign prog_rdata = rom[prog_addr];
  assign data_rdata = ram[data_addr];
  always @(posedge clock) if (data_we === 1'b1) ram[data_addr] <= data_wdata;
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      fails++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset(input logic wd);
    int n;
    reset = 1'b1;
    watchdog_enabled = wd;
    wake = 1'b0;
    repeat (4) @(negedge clock);
    rom[0] = 8'hf8;
    reset = 1'b0;
    pc = 12'h001;
    acc = 8'h00;
    cf = 1'b0;
    zf = 1'b0;
    stk.delete();
    n = 0;
    while (instr_done !== 1'b1 && n < 10) begin
      @(negedge clock);
      n++;
    end
  endtask

  // predict one instruction, run it, compare
  task automatic run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
    logic [11:0] np;
    logic [8:0]  s;
    logic [7:0]  m, wa, a;
    logic        w, sel;
    int          len, n;
    a = acc;
    np = pc + 12'h001;
    len = 2;
    w = 1'b0;
    wa = 8'h00;
    m = 8'h00;
    sel = op[5] ? cf : zf;
    rom[pc] = op;
    rom[pc + 12'h001] = b2;
    rom[pc + 12'h002] = b3;
    if (!op[7]) begin
      if (op[6] == sel) np = op[4] ? pc - {8'h00, op[3:0]} : pc + {8'h00, op[3:0]} + 12'h001;
    end else begin
      len = 4;
      case (op[6:4])
        3'h0, 3'h1: begin
          if (op[4]) stk.push_front(pc + 12'h002);
          if (stk.size() > STACK_DEPTH) void'(stk.pop_back());
          np = {op[3:0], b2};
        end
        3'h2: begin
          wa = b2;
          m = ram[b2];
          m[op[2:0]] = op[3];
          w = 1'b1;
          np = pc + 12'h002;
        end
        3'h3: begin
          len = 5;
          cf = ram[b2][op[2:0]];
          np = pc + ((cf == op[3]) ? 12'h002 + {{4{b3[7]}}, b3} : 12'h003);
        end
        3'h4, 3'h5: begin
          wa = op[1] ? ram[{7'h40, op[0]}] : b2;
          m = (op[1:0] == 2'h1) ? b2 : ram[wa];
          np = op[1] ? np : pc + 12'h002;
          case (op[4:2])
            3'h0: s = {1'b0, a} + {1'b0, m};
            3'h1: s = {1'b0, a & m};
            3'h2, 3'h3: s = {1'b0, a} - {1'b0, m};
            3'h4: s = 9'h000;
            3'h5: s = {1'b0, m + 8'h01};
            default: s = {1'b0, m - 8'h01};
          endcase
          if (op[4:2] < 3'h4) begin
            cf = s[8];
            zf = (s[7:0] == 8'h00);
            if (op[4:2] != 3'h2) acc = s[7:0];
          end else begin
            w = 1'b1;
            m = s[7:0];
            if (op[4:2] != 3'h4) zf = (m == 8'h00);
          end
        end
        3'h6: begin
          wa = {6'h20, op[1:0]};
          m = op[2] ? ram[wa] + 8'h01 : ram[wa] - 8'h01;
          zf = (m == 8'h00);
          w = 1'b1;
        end
        default: begin
          if (!op[3]) begin
            case (op[1:0])
              2'h0: s = {a[7], ~a};
              2'h1: s = {a, cf};
              default: s = {a, 1'b0};
            endcase
            cf = s[8];
            acc = s[7:0];
            zf = (acc == 8'h00);
          end else begin
            len = 2;
            if (op[2:0] != 3'h0) np = (stk.size() > 0) ? stk.pop_front() : 12'h000;
          end
        end
      endcase
    end
    irq_seen = 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      irq_seen = irq_seen | (irq_return === 1'b1);
    end while (instr_done !== 1'b1 && n < 12);
    chk_cnt(n, len);
    chk({prog_addr, acc_value, 2'b00, carry_flag, zero_flag},
        {np, acc, 2'b00, cf, zf});
    if (w) chk({16'h0000, ram[wa]}, {16'h0000, m});
    if (op == 8'hfa) chk({23'h000000, irq_seen}, 24'h000001);
    pc = np;
  endtask

  task automatic halt(input logic wd, input logic [7:0] op, input logic [1:0] exp);
    do_reset(wd);
    rom[1] = op;
    rom[2] = 8'hf8;
    repeat (6) @(negedge clock);
    chk({22'h000000, wait_mode, stop_mode}, {22'h000000, exp});
    wake = 1'b1;
    repeat (3) @(negedge clock);
    chk({22'h000000, wait_mode, stop_mode}, 24'h000000);
    wake = 1'b0;
  endtask

  initial begin
    logic [31:0] r;
    logic [7:0]  op;
    seed = 32'd2177;
    fails = 0;
    comparisons = 0;
    cycles = 0;
    reset = 1'b1;
    watchdog_enabled = 1'b0;
    wake = 1'b0;
    foreach (ram[i]) ram[i] = 8'(rnd());
    halt(1'b0, 8'hfb, 2'b01);
    halt(1'b1, 8'hfb, 2'b10);
    halt(1'b0, 8'hfc, 2'b10);
    do_reset(1'b0);
    run(8'hc1, 8'hff, 8'h00);
    run(8'hc1, 8'h01, 8'h00);
    for (int k = 0; k < 4; k++) begin
      run({1'b0, k[1:0], 5'h1f}, 8'h00, 8'h00);
      run({1'b0, k[1:0], 5'h0f}, 8'h00, 8'h00);
      run({6'h38, k[1:0]}, 8'h00, 8'h00);
      run({6'h39, k[1:0]}, 8'h00, 8'h00);
    end
    ram[8'hff] = 8'h80;
    run(8'hbf, 8'hff, 8'h80);
    run(8'hb0, 8'hff, 8'h7f);
    run(8'haf, 8'h00, 8'h00);
    run(8'ha0, 8'hff, 8'h00);
    run(8'hd4, 8'hff, 8'h00);
    run(8'hd8, 8'h00, 8'h00);
    run(8'hd0, 8'h7f, 8'h00);
    run(8'hf0, 8'h00, 8'h00);
    run(8'hf1, 8'h00, 8'h00);
    run(8'hf2, 8'h00, 8'h00);
    run(8'h8f, 8'hff, 8'h00);
    run(8'h93, 8'h45, 8'h00);
    run(8'hf9, 8'h00, 8'h00);
    run(8'h9a, 8'h10, 8'h00);
    run(8'hfa, 8'h00, 8'h00);
    repeat (400) begin
      r = rnd();
      op = r[7:0];
      if (op[7:5] == 3'h6 && (op[4:2] == 3'h7 || (op[4] && op[1:0] == 2'h1))) op[4] = 1'b0;
      if (op[7:3] == 5'h1f && op[2:0] > 3'h2) op = 8'hf8;
      if (op[7:3] == 5'h1e && op[1:0] == 2'h3) op[1:0] = 2'h0;
      run(op, r[15:8], r[23:16]);
    end
    end_of_test();
  end
endmodule

bind abx_exec abx_exec_sva u_abx_exec_sva (.clock(clock), .reset(reset),
  .prog_addr(prog_addr), .prog_rdata(prog_rdata), .data_addr(data_addr),
  .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we),
  .watchdog_enabled(watchdog_enabled), .wake(wake), .acc_value(acc_value),
  .carry_flag(carry_flag), .zero_flag(zero_flag), .wait_mode(wait_mode),
  .stop_mode(stop_mode), .irq_return(irq_return), .instr_done(instr_done));
`default_nettype wire
